// >>> pkg/dmacc_regs.svh
// register offsets, field positions, reset values and timing counts
// included by the package and the design top
`ifndef DMACC_REGS_SVH
`define DMACC_REGS_SVH
`define DMACC_CTRL_OFS      8'h00
`define DMACC_SETF_OFS      8'h04
`define DMACC_OUTF_OFS      8'h08
`define DMACC_AUX_OFS       8'h0C
`define DMACC_POWER_OFS     8'h10
`define DMACC_ECLR_OFS      8'h14
`define DMACC_TCLR_OFS      8'h18
`define DMACC_FSREF_OFS     8'h1C
`define DMACC_DISP_OFS      8'h20
`define DMACC_ESER_OFS      8'h24
`define DMACC_EFINE_OFS     8'h28
`define DMACC_EPU_OFS       8'h2C
`define DMACC_HOURS_OFS     8'h30
`define DMACC_OVF_OFS       8'h34
`define DMACC_IO_OFS        8'h38
`define DMACC_STAT_OFS      8'h3C
`define DMACC_SEL_LSB       0
`define DMACC_SHIFT_LSB     8
`define DMACC_DEC_LSB       24
`define DMACC_SEL_RST       8'h00
`define DMACC_SHIFT_RST     16'h270F
`define DMACC_DEC_RST       16'h270F
`define DMACC_ECLR_RST      16'h270F
`define DMACC_NOSET         16'h270F
`define DMACC_FS_FREQ_RST   16'h1388
`define DMACC_FS_FREQ_MAX   16'h9C40
`define DMACC_FS_CUR_MAX    16'hC350
`define DMACC_FS_CUR_RST    16'h0000
`define DMACC_CLK_HZ        25000000
`define DMACC_HOUR_S        3600
`define DMACC_HOUR_CYC      (`DMACC_CLK_HZ * 64'd`DMACC_HOUR_S)
`endif

// >>> pkg/dmacc_pkg.sv
// types shared by the drive monitor accumulator block
package dmacc_pkg;
`include "dmacc_regs.svh"
    typedef enum logic [5:0] {
        ST_STOP = 6'h01,
        ST_RUN = 6'h02,
        ST_ERR = 6'h04,
        ST_SHUT = 6'h08,
        ST_TUNE = 6'h10,
        ST_IDLE = 6'h20
    } dmacc_mode_t;
    typedef struct packed {
        logic running;
        logic error;
        logic shutoff;
        logic tuning;
    } dmacc_drv_t;
    typedef struct packed {
        logic [31:0] value;
        logic hz_lit;
        logic hz_blink;
        logic io_mode;
    } dmacc_disp_t;
endpackage

// >>> hw/dmacc_top.sv
// drive monitor selection, energy accumulator, hour counters and meter references
// assumes AXI4-Lite master on ref_clk_i; drive status inputs synchronous to the clock
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "dmacc_regs.svh"

// How it works
// - selection 100: set frequency when stopped, output frequency running, Hz blinks stopped
// - stopped set frequency is the limited, jump-applied start frequency
// - during error show output frequency captured when error began
// - output shutoff active shows the stopped-state values
// - offline tuning status overrides any selected display
// - selection 55 shows input and output terminals, centre segment lit
// - selection 25 accumulates power, displayed total refreshed hourly
// - four-digit panel energy resolution steps at 100 and 1000
// - five-digit unit energy up to 99999.99, coarser past 999.99
// - serial energy in 1 kWh to 9999 or 65535, plus 0.01 kWh item
// - energy shifted right by digit-shift decimal digits before showing
// - overflow clamps for shift 0 to 4, wraps to zero for 9999
// - writing zero clears energy; clear parameter never reads zero
// - selection 20 counts whole powered hours
// - selection 23 counts hours only while running
// - hour counters wrap after 65535; overflow counters record wraps
// - time clear zero resets running hours only; reads 9999
// - running hours advance only after a full continuous running hour
// - decimal setting 9999 none, 0 integer round, 1 drops hundredths
// - decimal setting leaves hour monitors untouched
// - meter full-scale refs: frequency 0-400 Hz default 50, current 0-500 A
// - full-scale refs writable only with extended setting zero, even running
module dmacc_top #(
    parameter longint HOUR_CYC = `DMACC_HOUR_CYC,
    parameter logic [15:0] FS_CUR_RST = `DMACC_FS_CUR_RST
) (
    input wire logic ref_clk_i, // system clock
    input wire logic rst_i, // sync reset, high
    input wire dmacc_pkg::dmacc_drv_t drv_i, // drive state flags
    input wire logic [15:0] tune_stat_i, // tuning status code
    input wire logic [15:0] out_cur_i, // output current, 0.01 units
    input wire logic [15:0] out_volt_i, // output voltage
    input wire logic [15:0] alarm_i, // alarm code
    input wire logic [7:0] in_term_i, // input terminal states
    input wire logic [7:0] out_term_i, // output terminal states
    input wire logic ext_par_zero_i, // extended-parameter setting is zero
    input wire logic [31:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [31:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output dmacc_pkg::dmacc_disp_t disp_o, // panel display word
    output logic [15:0] am_freq_fs_o, // analog_meter_output frequency reference
    output logic [15:0] am_cur_fs_o // analog_meter_output current reference
);
    import dmacc_pkg::*;

    // settings
    logic [7:0] disp_sel;
    logic [15:0] shift_set, dec_set, eclr_rd, fs_freq, fs_cur;
    logic [15:0] set_freq, out_freq, max_f, min_f, jump_lo, jump_hi, power_in;
    logic [15:0] err_freq;
    logic err_d;
    // accumulators: energy in 0.01 kWh (power 0.01 kW added once per hour tick)
    logic [63:0] hour_cnt;
    logic hour_tick;
    logic [63:0] e_sum;
    logic [31:0] e_raw;
    logic [15:0] en_hours, run_hours, en_ovf, run_ovf;
    logic [63:0] run_cyc;
    logic run_full;
    dmacc_mode_t mode;

    function automatic logic [31:0] div10n(input logic [31:0] v, input logic [15:0] n);
        logic [31:0] r;
        r = v;
        for (int i = 0; i < 4; i++)
            if (16'(i) < n)
                r = r / 32'd10;
        return r;
    endfunction

    // applied start frequency after limits and jump band
    function automatic logic [15:0] lim_freq(input logic [15:0] f, input logic [15:0] lo,
        input logic [15:0] hi, input logic [15:0] jl, input logic [15:0] jh);
        logic [15:0] r;
        r = f;
        if (r > hi)
            r = hi;
        if (r < lo)
            r = lo;
        if (r > jl && r < jh)
            r = jl;
        return r;
    endfunction

    // hourly tick from system clock
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i || hour_tick)
            hour_cnt <= 64'h0;
        else
            hour_cnt <= hour_cnt + 64'h1;
    end
    assign hour_tick = (hour_cnt == HOUR_CYC - 64'd1);

    // AXI4-Lite write path; address and data taken in either order
    logic aw_h, w_h;
    logic [7:0] aw_a;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic do_wr;
    assign do_wr = aw_h && w_h && !s_axi_bvalid;
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            aw_h <= 1'b0;
            w_h <= 1'b0;
            aw_a <= 8'h00;
            w_d <= 32'h0;
            w_s <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_h <= 1'b1;
                aw_a <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_h <= 1'b1;
                w_d <= s_axi_wdata;
                w_s <= s_axi_wstrb;
            end
            if (do_wr)
            begin
                aw_h <= 1'b0;
                w_h <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_a[1:0] != 2'h0 || aw_a > `DMACC_IO_OFS
                    || aw_a >= `DMACC_DISP_OFS) ? 2'h2 : 2'h0;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_h && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_h && !(s_axi_wvalid && s_axi_wready);
        end
    end

    function automatic logic [15:0] merge(input logic [15:0] o, input logic [31:0] d,
        input logic [3:0] s, input logic hi);
        logic [15:0] r;
        r = o;
        if (s[hi ? 2 : 0])
            r[7:0] = hi ? d[23:16] : d[7:0];
        if (s[hi ? 3 : 1])
            r[15:8] = hi ? d[31:24] : d[15:8];
        return r;
    endfunction

    logic wr_ctrl, wr_setf, wr_outf, wr_aux, wr_pow, wr_eclr, wr_tclr, wr_fs;
    assign wr_ctrl = do_wr && aw_a == `DMACC_CTRL_OFS;
    assign wr_setf = do_wr && aw_a == `DMACC_SETF_OFS;
    assign wr_outf = do_wr && aw_a == `DMACC_OUTF_OFS;
    assign wr_aux = do_wr && aw_a == `DMACC_AUX_OFS;
    assign wr_pow = do_wr && aw_a == `DMACC_POWER_OFS;
    assign wr_eclr = do_wr && aw_a == `DMACC_ECLR_OFS && w_s[1:0] == 2'h3;
    assign wr_tclr = do_wr && aw_a == `DMACC_TCLR_OFS && w_s[1:0] == 2'h3;
    assign wr_fs = do_wr && aw_a == `DMACC_FSREF_OFS;

    // software settings
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            disp_sel <= `DMACC_SEL_RST;
            shift_set <= `DMACC_SHIFT_RST;
            dec_set <= `DMACC_DEC_RST;
            set_freq <= 16'h0;
            max_f <= 16'hFFFF;
            out_freq <= 16'h0;
            min_f <= 16'h0;
            jump_lo <= 16'h0;
            jump_hi <= 16'h0;
            power_in <= 16'h0;
        end
        else
        begin
            if (wr_ctrl && w_s[0])
                disp_sel <= w_d[7:0];
            if (wr_ctrl)
                shift_set <= merge(shift_set, {8'h00, w_d[31:8]}, w_s[3:1] == 3'h7 ?
                    4'h3 : 4'h0, 1'b0);
            if (wr_setf)
            begin
                set_freq <= merge(set_freq, w_d, w_s, 1'b0);
                max_f <= merge(max_f, w_d, w_s, 1'b1);
            end
            if (wr_outf)
            begin
                out_freq <= merge(out_freq, w_d, w_s, 1'b0);
                min_f <= merge(min_f, w_d, w_s, 1'b1);
            end
            if (wr_aux)
            begin
                jump_lo <= merge(jump_lo, w_d, w_s, 1'b0);
                jump_hi <= merge(jump_hi, w_d, w_s, 1'b1);
            end
            if (wr_pow)
            begin
                power_in <= merge(power_in, w_d, w_s, 1'b0);
                dec_set <= merge(dec_set, w_d, w_s, 1'b1);
            end
        end
    end

    // full-scale references, guarded by extended setting, allowed while running
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            fs_freq <= `DMACC_FS_FREQ_RST;
            fs_cur <= FS_CUR_RST;
        end
        else if (wr_fs && ext_par_zero_i)
        begin
            if (w_s[1:0] == 2'h3 && w_d[15:0] <= `DMACC_FS_FREQ_MAX)
                fs_freq <= w_d[15:0];
            if (w_s[3:2] == 2'h3 && w_d[31:16] <= `DMACC_FS_CUR_MAX)
                fs_cur <= w_d[31:16];
        end
    end

    // energy accumulator; limit at 99999.99 kWh in 0.01 units
    localparam logic [31:0] E_MAX = 32'd9999999;
    logic [63:0] e_next;
    always_comb
    begin
        e_next = e_sum + {48'h0, power_in};
    end
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i || (wr_eclr && w_d[15:0] == 16'h0000))
        begin
            e_sum <= 64'h0;
            e_raw <= 32'h0;
        end
        else if (hour_tick)
        begin
            // hourly sample of power, shown total refreshed each hour
            if (e_next > {32'h0, E_MAX})
                e_sum <= (shift_set == `DMACC_NOSET) ? 64'h0 : {32'h0, E_MAX};
            else
                e_sum <= e_next;
            e_raw <= (e_next > {32'h0, E_MAX}) ?
                ((shift_set == `DMACC_NOSET) ? 32'h0 : E_MAX) : e_next[31:0];
        end
    end
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            eclr_rd <= `DMACC_ECLR_RST;
        else if (wr_eclr)
            eclr_rd <= (w_d[15:0] == 16'd10) ? 16'd10 : `DMACC_ECLR_RST;
    end

    // hour counters
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            en_hours <= 16'h0;
            en_ovf <= 16'h0;
        end
        else if (hour_tick)
        begin
            en_hours <= en_hours + 16'h1;
            if (en_hours == 16'hFFFF)
                en_ovf <= en_ovf + 16'h1;
        end
    end
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i || !drv_i.running || run_full)
            run_cyc <= 64'h0;
        else
            run_cyc <= run_cyc + 64'h1;
    end
    assign run_full = drv_i.running && run_cyc == HOUR_CYC - 64'd1;
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            run_hours <= 16'h0;
            run_ovf <= 16'h0;
        end
        else if (wr_tclr && w_d[15:0] == 16'h0000)
            run_hours <= 16'h0;
        else if (run_full)
        begin
            run_hours <= run_hours + 16'h1;
            if (run_hours == 16'hFFFF)
                run_ovf <= run_ovf + 16'h1;
        end
    end

    // error capture of output frequency
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            err_d <= 1'b0;
            err_freq <= 16'h0;
        end
        else
        begin
            err_d <= drv_i.error;
            if (drv_i.error && !err_d)
                err_freq <= out_freq;
        end
    end

    always_comb
    begin
        if (drv_i.tuning)
            mode = ST_TUNE;
        else if (drv_i.error)
            mode = ST_ERR;
        else if (drv_i.shutoff || !drv_i.running)
            mode = ST_STOP;
        else
            mode = ST_RUN;
    end

    // decimal rounding: v in 0.01 units
    function automatic logic [31:0] dec_fmt(input logic [31:0] v, input logic [15:0] d);
        if (d == 16'h0)
            return ((v + 32'd50) / 32'd100) * 32'd100;
        else if (d == 16'h1)
            return (v / 32'd10) * 32'd10;
        else
            return v;
    endfunction

    logic [31:0] e_sh, e_panel, e_pu, e_ser;
    always_comb
    begin
        e_sh = div10n(e_raw, shift_set == `DMACC_NOSET ? 16'h0 : shift_set);
        // panel 4 digits; resolution coarsens at 100.00 and 1000.0 kWh
        if (e_sh < 32'd10000)
            e_panel = e_sh;
        else if (e_sh < 32'd100000)
            e_panel = (e_sh / 32'd10) * 32'd10;
        else if (e_sh < 32'd1000000)
            e_panel = (e_sh / 32'd100) * 32'd100;
        else
            e_panel = 32'd999900;
        e_pu = (e_sh < 32'd100000) ? e_sh : (e_sh / 32'd10) * 32'd10;
        e_ser = e_sh / 32'd100;
        if (eclr_rd == 16'd10 && e_ser > 32'd9999)
            e_ser = 32'd9999;
        else if (e_ser > 32'd65535)
            e_ser = 32'd65535;
    end

    dmacc_disp_t next_disp;
    always_comb
    begin
        next_disp = '0;
        case (mode)
            ST_TUNE: next_disp.value = {16'h0, tune_stat_i};
            ST_ERR: next_disp.value = {16'h0, err_freq};
            default:
            begin
                case (disp_sel)
                    8'd100:
                        next_disp.value = (mode == ST_STOP) ?
                            {16'h0, lim_freq(set_freq, min_f, max_f, jump_lo, jump_hi)} :
                            {16'h0, out_freq};
                    8'd5: next_disp.value = {16'h0, set_freq};
                    8'd2: next_disp.value = {16'h0, out_cur_i};
                    8'd3: next_disp.value = {16'h0, out_volt_i};
                    8'd55:
                    begin
                        next_disp.value = {8'h0, in_term_i, 8'h01, out_term_i};
                        next_disp.io_mode = 1'b1;
                    end
                    8'd25: next_disp.value = e_panel;
                    8'd20: next_disp.value = {16'h0, en_hours};
                    8'd23: next_disp.value = {16'h0, run_hours};
                    8'd0: next_disp.value = {16'h0, alarm_i};
                    default: next_disp.value = {16'h0, out_freq};
                endcase
                if (!(disp_sel inside {8'd0, 8'd20, 8'd23, 8'd55, 8'd25}))
                    next_disp.value = dec_fmt(next_disp.value, dec_set);
                next_disp.hz_blink = (disp_sel == 8'd100) && mode == ST_STOP;
                next_disp.hz_lit = (disp_sel == 8'd100) && mode == ST_RUN;
            end
        endcase
    end
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            disp_o <= '0;
            am_freq_fs_o <= `DMACC_FS_FREQ_RST;
            am_cur_fs_o <= FS_CUR_RST;
        end
        else
        begin
            disp_o <= next_disp;
            am_freq_fs_o <= fs_freq;
            am_cur_fs_o <= fs_cur;
        end
    end

    // read path
    logic [31:0] rmux;
    always_comb
    begin
        case (s_axi_araddr[7:0])
            `DMACC_CTRL_OFS: rmux = {shift_set[15:0], 8'h0, disp_sel};
            `DMACC_SETF_OFS: rmux = {max_f, set_freq};
            `DMACC_OUTF_OFS: rmux = {min_f, out_freq};
            `DMACC_AUX_OFS: rmux = {jump_hi, jump_lo};
            `DMACC_POWER_OFS: rmux = {dec_set, power_in};
            `DMACC_ECLR_OFS: rmux = {16'h0, eclr_rd};
            `DMACC_TCLR_OFS: rmux = {16'h0, `DMACC_NOSET};
            `DMACC_FSREF_OFS: rmux = {fs_cur, fs_freq};
            `DMACC_DISP_OFS: rmux = disp_o.value;
            `DMACC_ESER_OFS: rmux = e_ser;
            `DMACC_EFINE_OFS: rmux = e_sh;
            `DMACC_EPU_OFS: rmux = e_pu;
            `DMACC_HOURS_OFS: rmux = {run_hours, en_hours};
            `DMACC_OVF_OFS: rmux = {run_ovf, en_ovf};
            `DMACC_IO_OFS: rmux = {16'h0, in_term_i, out_term_i};
            `DMACC_STAT_OFS: rmux = {26'h0, mode};
            default: rmux = 32'h0;
        endcase
    end
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rmux;
            s_axi_rresp <= (s_axi_araddr[1:0] != 2'h0 || s_axi_araddr[7:0] > `DMACC_STAT_OFS)
                ? 2'h2 : 2'h0;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else
            s_axi_arready <= 1'b1;
    end
endmodule

// >>> bench/dmacc_monitor.sv
// port checker for the monitor accumulator block
// bound into dmacc_top; sees its ports only
`timescale 1ns/1ps
module dmacc_monitor (
    input wire logic ref_clk_i, // clock
    input wire logic rst_i, // reset
    input wire dmacc_pkg::dmacc_drv_t drv_i, // drive flags
    input wire logic [15:0] tune_stat_i, // tuning code
    input wire logic ext_par_zero_i, // ref unlock
    input wire logic [31:0] s_axi_araddr, // read addr
    input wire logic s_axi_arvalid, // addr valid
    input wire logic s_axi_arready, // addr ready
    input wire logic [31:0] s_axi_rdata, // read data
    input wire logic [1:0] s_axi_rresp, // read resp
    input wire logic s_axi_rvalid, // read valid
    input wire logic s_axi_rready, // read ready
    input wire logic s_axi_bvalid, // resp valid
    input wire logic s_axi_bready, // resp ready
    input wire dmacc_pkg::dmacc_disp_t disp_o, // display
    input wire logic [15:0] am_freq_fs_o, // freq ref
    input wire logic [15:0] am_cur_fs_o // current ref
);
    import dmacc_pkg::*;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data not held");
    AST_RD_ERR: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 32'h40
        |=> s_axi_rvalid && s_axi_rresp == 2'h2) else $error("unmapped read not refused");
    AST_FREQ_MAX: assert property (am_freq_fs_o <= 16'h9C40)
        else $error("frequency reference out of range");
    AST_CUR_MAX: assert property (am_cur_fs_o <= 16'hC350)
        else $error("current reference out of range");
    AST_FS_LOCK: assert property (!ext_par_zero_i |=> $stable(am_freq_fs_o)
        && $stable(am_cur_fs_o)) else $error("reference changed while locked");
    AST_TUNE: assert property (drv_i.tuning ##1 1 |-> disp_o.value == $past(tune_stat_i))
        else $error("tuning status not shown");
    AST_HZ_STOP: assert property (!drv_i.running && !drv_i.error |=> !disp_o.hz_lit)
        else $error("hz lit while stopped");
endmodule
bind dmacc_top dmacc_monitor u_mon (.ref_clk_i, .rst_i, .drv_i, .tune_stat_i,
    .ext_par_zero_i, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready,
    .disp_o, .am_freq_fs_o, .am_cur_fs_o);

// >>> bench/dmacc_panel.sv
// operator panel model: latches digits and hz indicator
// fed by the display word; adds one cycle of latency
`timescale 1ns/1ps
module dmacc_panel (
    input wire logic ref_clk_i, // clock
    input wire dmacc_pkg::dmacc_disp_t disp_i, // display word
    output logic [31:0] shown_o, // digits
    output logic [1:0] hz_o // lit, blink
);
    import dmacc_pkg::*;
    always_ff @(posedge ref_clk_i)
    begin
        shown_o <= disp_i.value;
        hz_o <= {disp_i.hz_lit, disp_i.hz_blink};
    end
endmodule

// >>> bench/dmacc_top_test.sv
// self-checking bench for the monitor accumulator block
// hour shortened to 100 cycles; panel model watches the display
`timescale 1ns/1ps
module dmacc_top_test;
    import dmacc_pkg::*;
    logic ref_clk_i = 0, rst_i = 1, ext = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rd, rdata, shown, h1, e1, h2, e2;
    logic [31:0] seed = 32'h85C3;
    logic [15:0] tune = 0, p = 0, f, of, amf, amc;
    logic [1:0] bresp, rresp, rs, hz;
    dmacc_drv_t drv = '0;
    dmacc_disp_t disp;
    int err_count = 0, n_tests = 0, cyc = 0;
    dmacc_top #(.HOUR_CYC(100)) dut (.ref_clk_i, .rst_i, .drv_i(drv), .tune_stat_i(tune),
        .out_cur_i(tune), .out_volt_i(~tune), .alarm_i(p), .in_term_i(tune[7:0]),
        .out_term_i(tune[15:8]), .ext_par_zero_i(ext), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .disp_o(disp), .am_freq_fs_o(amf), .am_cur_fs_o(amc));
    dmacc_panel u_panel (.ref_clk_i, .disp_i(disp), .shown_o(shown), .hz_o(hz));
    initial forever #20 ref_clk_i = ~ref_clk_i;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] lim(input logic [15:0] v);
        return (v > 16'd6000) ? 16'd6000 : v;
    endfunction
    task tally_and_finish();
        if (err_count == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge ref_clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            tally_and_finish();
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (e !== g)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        awaddr <= {24'h0, a};
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do
        begin
            @(posedge ref_clk_i);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end
        while (!bvalid);
        rs = bresp;
        bready <= 0;
        repeat (2) @(posedge ref_clk_i);
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge ref_clk_i);
        araddr <= {24'h0, a};
        arvalid <= 1;
        rready <= 1;
        do
        begin
            @(posedge ref_clk_i);
            if (arvalid && arready) arvalid <= 0;
        end
        while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 0;
    endtask
    // hours re-read so a tick between reads is not mistaken for a fault
    task automatic snap(output logic [31:0] h, output logic [31:0] e);
        logic [31:0] h0;
        do
        begin
            rdr(8'h30);
            h0 = rd;
            rdr(8'h28);
            e = rd;
            rdr(8'h30);
            h = rd;
        end
        while (h !== h0);
    endtask
    initial
    begin
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 0;
        @(posedge ref_clk_i);
        chk("fs_rst", 32'h00001388, {amc, amf});
        wr(8'h1C, 32'h00010064);
        chk("fs_locked", 32'h00001388, {amc, amf});
        ext <= 1;
        wr(8'h1C, 32'hC3509C40);
        chk("fs_max", 32'hC3509C40, {amc, amf});
        wr(8'h1C, 32'hC3519C41);
        chk("fs_over", 32'hC3509C40, {amc, amf});
        wr(8'h20, 32'h0);
        chk("ro_write", 2'h2, rs);
        rdr(8'h40);
        chk("unmapped_rd", 2'h2, rs);
        wr(8'h00, {8'h00, 16'h270F, 8'd100});
        wr(8'h0C, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            of = seed[15:0] % 16'd9000;
            f = (i == 3) ? 16'd7999 : seed[31:16] % 16'd8000;
            wr(8'h08, {16'h0, of});
            wr(8'h04, {16'd6000, f});
            chk("stop_val", lim(f), shown);
            chk("stop_hz", 2'b01, hz);
            drv.running <= 1;
            repeat (4) @(posedge ref_clk_i);
            chk("run_val", of, shown);
            chk("run_hz", 2'b10, hz);
            drv.shutoff <= 1;
            repeat (4) @(posedge ref_clk_i);
            chk("shut_val", lim(f), shown);
            tune <= seed[23:8];
            drv.tuning <= 1;
            repeat (4) @(posedge ref_clk_i);
            chk("tune_val", tune, shown);
            drv <= 4'b1100; // running with error
            repeat (4) @(posedge ref_clk_i);
            wr(8'h08, {16'h0, ~of});
            chk("err_val", of, shown);
            drv <= '0;
        end
        p <= {7'h0, seed[8:0]} + 16'd1;
        @(posedge ref_clk_i);
        wr(8'h10, {16'h270F, p});
        wr(8'h14, 32'h0);
        rdr(8'h14);
        chk("eclr_rd", 32'h270F, rd);
        rdr(8'h18);
        chk("tclr_rd", 32'h270F, rd);
        snap(h1, e1);
        repeat (330) @(posedge ref_clk_i);
        snap(h2, e2);
        chk("energy", p * (h2[15:0] - h1[15:0]), e2 - e1);
        chk("run_short", 32'h0, h2[31:16]);
        drv.running <= 1;
        repeat (250) @(posedge ref_clk_i);
        snap(h2, e2);
        chk("run_hrs", 32'h2, h2[31:16]);
        drv <= '0;
        wr(8'h18, 32'h270F);
        snap(h2, e2);
        chk("run_keep", 32'h2, h2[31:16]);
        wr(8'h18, 32'h0);
        snap(h2, e2);
        chk("run_clr", 32'h0, h2[31:16]);
        chk("en_kept", 1'b1, h2[15:0] > h1[15:0]);
        wr(8'h00, {8'h00, 16'h270F, 8'd55});
        chk("io_term", {8'h0, tune[7:0], 8'h01, tune[15:8]}, shown);
        chk("io_mode", 1'b1, disp.io_mode);
        chk("io_hz", 2'b00, hz);
        // raw setting 79.99 rounds up to a whole 80 with decimal setting 0
        wr(8'h10, {16'h0, p});
        wr(8'h00, {8'h00, 16'h270F, 8'd5});
        chk("dec0", 32'd8000, shown);
        tally_and_finish();
    end
endmodule
